/* File: common/sic_pkg.sv */
// Shared constants and types for the SMBus slave with interrupt controller
package sic_pkg;
   // Bus addressing
   localparam logic [6:0] SLAVE_ADDR = 7'h09;
   localparam logic       RW_WRITE   = 1'h0;
   localparam logic       RW_READ    = 1'h1;
   localparam logic [3:0] BYTE_BITS  = 4'h8;

   // Sub-address map
   localparam logic [7:0] PTR_CMD0 = 8'h00;
   localparam logic [7:0] PTR_CMD1 = 8'h01;
   localparam logic [7:0] PTR_CMD2 = 8'h02;
   localparam logic [7:0] PTR_ST0  = 8'h03;
   localparam logic [7:0] PTR_ST1  = 8'h04;
   localparam logic [7:0] PTR_ST2  = 8'h05;
   localparam logic [7:0] PTR_MASK = 8'h06;
   localparam logic [7:0] PTR_SPARE = 8'h07;
   localparam logic [1:0] IDX_MASK = 2'h3;
   localparam logic [7:0] READ_IDLE = 8'hFF;
   localparam logic [7:0] READ_NONE = 8'h00;
   localparam logic [7:0] CMD_RESET = 8'h00;
   localparam logic [7:0] MASK_RESET = 8'h00;

   // Input current limit fields sit in the low bits of command bytes 0 and 1
   localparam int unsigned ILIM_LSB  = 0;
   localparam int unsigned ILIM_MSB  = 4;
   localparam logic [4:0]  ILIM_100MA = 5'h00;
   localparam logic [4:0]  ILIM_RSET  = 5'h1F;

   // Mask bit positions
   localparam int unsigned MB_CHARGER = 7;
   localparam int unsigned MB_FAULT   = 6;
   localparam int unsigned MB_EXTPWR  = 5;
   localparam int unsigned MB_HOSTPWR = 4;
   localparam int unsigned MB_LIMIT   = 3;
   localparam int unsigned MB_UVLIM   = 2;

   // Trigger bits over {status 0x03, status 0x04}
   localparam logic [15:0] TRG_CHARGER = 16'hE000;
   localparam logic [15:0] TRG_FAULT   = 16'h1818;
   localparam logic [15:0] TRG_EXTPWR  = 16'h00E0;
   localparam logic [15:0] TRG_HOSTPWR = 16'h0600;
   localparam logic [15:0] TRG_LIMIT   = 16'h0004;
   localparam logic [15:0] TRG_UVLIM   = 16'h0002;

   // Controller timing
   localparam int unsigned CLK_HZ  = 40000000;
   localparam int unsigned SCL_HZ  = 100000;
   localparam logic [7:0]  QTR_CYC = 8'(CLK_HZ / (4 * SCL_HZ));

   // Controller register port
   localparam logic [2:0] HR_CTRL = 3'h0;
   localparam logic [2:0] HR_CMD  = 3'h1;
   localparam logic [2:0] HR_DATA = 3'h2;
   localparam logic [2:0] HR_STAT = 3'h3;
   localparam logic [2:0] HR_RXD  = 3'h4;
   localparam int unsigned SB_BUSY = 0;
   localparam int unsigned SB_NACK = 1;
   localparam int unsigned SB_IRQ  = 2;

   typedef enum logic [1:0] {K_WRBYTE, K_RDBYTE, K_SEND, K_RECV} sic_kind_t;
   typedef enum logic [2:0] {OP_START, OP_AW, OP_AR, OP_CMD, OP_DATA, OP_RX, OP_STOP}
      sic_op_t;
endpackage : sic_pkg

/* File: common/sic_smb_if.sv */
// Two-wire link between bus controller and slave, open-drain data line
interface sic_smb_if;
   logic scl;
   logic m_sda_o;
   logic m_sda_oen;
   logic s_sda_o;
   logic s_sda_oen;
   logic irq_n;
   logic sda;

   // Wired-AND of both open-drain drivers, pulled high when released
   assign sda = (m_sda_oen | m_sda_o) & (s_sda_oen | s_sda_o);

   modport master (output scl, output m_sda_o, output m_sda_oen, input sda, input irq_n);
   modport slave  (input scl, input sda, output s_sda_o, output s_sda_oen, output irq_n);
endinterface : sic_smb_if

/* File: hdl/sic_pin_sync.sv */
// Two-stage synchroniser with one extra stage for edge detection
module sic_pin_sync #(
   parameter int unsigned     W       = 2,
   parameter logic [W-1:0]    RST_VAL = '1
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         resetn_i,
   // Pins and synchronised view
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] lvl_o,
   output logic      [W-1:0] prv_o
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
   } sic_sync_t;

   sic_sync_t q;
   sic_sync_t d;

   always_comb begin
      d    = q;
      d.s1 = async_i;
      d.s2 = q.s1;
      d.s3 = q.s2;
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         q <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL};
      end else begin
         q <= d;
      end
   end

   assign lvl_o = q.s2;
   assign prv_o = q.s3;
endmodule : sic_pin_sync

/* File: hdl/sic_slave.sv */
// SMBus slave end: sub-addressed registers, pending writes, interrupt controller
// Operation
// - Write byte: address, command, data, all acknowledged
// - Answer address 0x09 for write and read
// - Master writes only to writable pointers
// - STOP moves pending data into command registers
// - Combined read returns selected register byte
// - One byte per read, master acknowledge ignored
// - Send byte loads pointer only
// - Receive byte returns selected register, keeps pointer
// - Pointer persists until a write loads it
// - Interrupt line held low as level
// - Interrupt freezes status bytes, never commands
// - Mask at 0x06, six upper enable bits
// - All categories masked after reset
// - Data write to 0x06 clears interrupt
// - Master rewrites old mask to clear
// - Trigger bits grouped by category
// - Power-on reloads current limit default mode
// - Limit fields read back active mode
// - Writing resistor mode code selects default
// - Default codes 0x00 and 0x1F
// - Reads of written locations show pending data
// - Status sampled at read address acknowledge
// - Extra read clocks see 0xFF, no acknowledge
module sic_slave (
   // Clock and reset
   input  wire logic            clk_i,
   input  wire logic            resetn_i,
   // Link
   sic_smb_if.slave             smb,
   // Live status bytes 0x03..0x05, same clock domain
   input  wire logic [2:0][7:0] status_i,
   // Input power present and resistor default strap, same clock domain
   input  wire logic            input_power_i,
   input  wire logic            rset_default_i,
   // Active command registers 0x00, 0x01, 0x02, 0x06
   output logic      [3:0][7:0] cmd_o,
   output logic                 irq_pending_o
);
   typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_TX, S_DONE} sic_sst_t;

   typedef struct packed {
      sic_sst_t        st;
      logic [3:0]      cnt;
      logic [7:0]      sh;
      logic            abyte;
      logic            rd;
      logic            wptr;
      logic [7:0]      ptr;
      logic [3:0][7:0] cmd;
      logic [3:0][7:0] pend;
      logic [3:0]      pval;
      logic [2:0][7:0] snap;
      logic [15:0]     last;
      logic            irqp;
      logic            irq_n;
      logic            pwr;
      logic            sda_oen;
   } sic_slv_t;

   sic_slv_t   q;
   sic_slv_t   d;
   logic [1:0] lvl;
   logic [1:0] prv;
   logic       scl_rise;
   logic       scl_fall;
   logic       start;
   logic       stop;
   logic       clr;
   logic       trig;
   logic [4:0] dflt;
   logic [15:0] live;

   localparam int unsigned MB_CHARGER = sic_pkg::MB_CHARGER;
   localparam int unsigned MB_FAULT   = sic_pkg::MB_FAULT;
   localparam int unsigned MB_EXTPWR  = sic_pkg::MB_EXTPWR;
   localparam int unsigned MB_HOSTPWR = sic_pkg::MB_HOSTPWR;
   localparam int unsigned MB_LIMIT   = sic_pkg::MB_LIMIT;
   localparam int unsigned MB_UVLIM   = sic_pkg::MB_UVLIM;
   localparam logic [7:0]  PTR_CMD0   = sic_pkg::PTR_CMD0;
   localparam logic [7:0]  PTR_CMD1   = sic_pkg::PTR_CMD1;
   localparam logic [7:0]  PTR_CMD2   = sic_pkg::PTR_CMD2;
   localparam logic [7:0]  PTR_MASK   = sic_pkg::PTR_MASK;
   localparam logic [7:0]  PTR_ST0    = sic_pkg::PTR_ST0;
   localparam logic [7:0]  PTR_ST1    = sic_pkg::PTR_ST1;
   localparam logic [7:0]  PTR_ST2    = sic_pkg::PTR_ST2;
   localparam logic [7:0]  READ_NONE  = sic_pkg::READ_NONE;
   localparam logic [1:0]  IDX_MASK   = sic_pkg::IDX_MASK;
   localparam int unsigned ILIM_MSB   = sic_pkg::ILIM_MSB;
   localparam int unsigned ILIM_LSB   = sic_pkg::ILIM_LSB;

   // Writable location to command slot; 0x07 is accepted but holds nothing
   function automatic logic [2:0] wslot(input logic [7:0] p);
      case (p)
         PTR_CMD0: wslot = 3'h4;
         PTR_CMD1: wslot = 3'h5;
         PTR_CMD2: wslot = 3'h6;
         PTR_MASK: wslot = 3'h7;
         default:  wslot = 3'h0;
      endcase
   endfunction : wslot

   function automatic logic [7:0] rd_byte(input logic [7:0] p, input sic_slv_t s);
      logic [2:0] w;
      w = wslot(p);
      if (w[2]) begin
         rd_byte = s.pval[w[1:0]] ? s.pend[w[1:0]] : s.cmd[w[1:0]];
      end else begin
         case (p)
            PTR_ST0: rd_byte = s.snap[0];
            PTR_ST1: rd_byte = s.snap[1];
            PTR_ST2: rd_byte = s.snap[2];
            default: rd_byte = READ_NONE;
         endcase
      end
   endfunction : rd_byte

   function automatic logic [15:0] trig_en(input logic [7:0] m);
      trig_en = ({16{m[MB_CHARGER]}} & sic_pkg::TRG_CHARGER)
              | ({16{m[MB_FAULT]}}   & sic_pkg::TRG_FAULT)
              | ({16{m[MB_EXTPWR]}}  & sic_pkg::TRG_EXTPWR)
              | ({16{m[MB_HOSTPWR]}} & sic_pkg::TRG_HOSTPWR)
              | ({16{m[MB_LIMIT]}}   & sic_pkg::TRG_LIMIT)
              | ({16{m[MB_UVLIM]}}   & sic_pkg::TRG_UVLIM);
   endfunction : trig_en

   sic_pin_sync #(.W(2), .RST_VAL(2'h3)) u_sync (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .async_i  ({smb.scl, smb.sda}),
      .lvl_o    (lvl),
      .prv_o    (prv)
   );

   assign scl_rise = lvl[1] & ~prv[1];
   assign scl_fall = ~lvl[1] & prv[1];
   assign start    = lvl[1] & prv[1] & prv[0] & ~lvl[0];
   assign stop     = lvl[1] & prv[1] & ~prv[0] & lvl[0];
   assign live     = {status_i[0], status_i[1]};
   assign dflt     = rset_default_i ? sic_pkg::ILIM_RSET : sic_pkg::ILIM_100MA;

   always_comb begin
      logic [2:0] w;
      w    = 3'h0;
      d    = q;
      clr  = 1'b0;
      if (start) begin
         d.st      = S_RX;
         d.cnt     = '0;
         d.abyte   = 1'b1;
         d.wptr    = 1'b1;
         d.sda_oen = 1'b1;
      end else if (stop) begin
         d.st      = S_IDLE;
         d.sda_oen = 1'b1;
         for (int i = 0; i < 4; i++) begin
            if (q.pval[i]) begin
               d.cmd[i] = q.pend[i];
            end
         end
         d.pval = '0;
      end else begin
         case (q.st)
            S_RX: begin
               if (scl_rise) begin
                  d.sh  = {q.sh[6:0], lvl[0]};
                  d.cnt = q.cnt + 4'h1;
               end
               if (scl_fall && q.cnt == sic_pkg::BYTE_BITS) begin
                  d.st      = S_ACK;
                  d.sda_oen = 1'b0;
                  if (q.abyte) begin
                     if (q.sh[7:1] == sic_pkg::SLAVE_ADDR) begin
                        d.rd = (q.sh[0] == sic_pkg::RW_READ);
                        if (q.sh[0] == sic_pkg::RW_READ && !q.irqp) begin
                           d.snap = status_i;
                        end
                     end else begin
                        d.st      = S_DONE;
                        d.sda_oen = 1'b1;
                     end
                  end else if (q.wptr) begin
                     d.ptr  = q.sh;
                     d.wptr = 1'b0;
                  end else begin
                     w      = wslot(q.ptr);
                     d.wptr = 1'b1;
                     if (w[2]) begin
                        d.pend[w[1:0]] = q.sh;
                        d.pval[w[1:0]] = 1'b1;
                     end
                     clr = (q.ptr == PTR_MASK);
                  end
               end
            end
            S_ACK: begin
               if (scl_fall) begin
                  d.cnt   = '0;
                  d.abyte = 1'b0;
                  if (q.abyte && q.rd) begin
                     d.st      = S_TX;
                     d.sh      = rd_byte(q.ptr, q);
                     d.sda_oen = d.sh[7];
                  end else begin
                     d.st      = S_RX;
                     d.sda_oen = 1'b1;
                  end
               end
            end
            S_TX: begin
               if (scl_rise) begin
                  d.cnt = q.cnt + 4'h1;
               end
               if (scl_fall) begin
                  if (q.cnt == sic_pkg::BYTE_BITS) begin
                     // Master ACK or NACK alike: the line stays released
                     d.st      = S_DONE;
                     d.sda_oen = 1'b1;
                  end else begin
                     d.sh      = {q.sh[6:0], 1'b1};
                     d.sda_oen = q.sh[6];
                  end
               end
            end
            S_DONE: d.sda_oen = 1'b1;
            S_IDLE: d.sda_oen = 1'b1;
            default: begin
               d.st      = S_IDLE;
               d.sda_oen = 1'b1;
            end
         endcase
      end

      // Interrupt: a trigger in the clearing cycle re-arms at once
      d.last = live;
      trig   = |((live ^ q.last) & trig_en(q.cmd[IDX_MASK])) && (!q.irqp || clr);
      if (clr) begin
         d.irqp = 1'b0;
      end
      if (trig) begin
         d.irqp = 1'b1;
         d.snap = status_i;
      end
      d.irq_n = ~d.irqp;

      // Power reapplied overrides the limit fields of any commit in the same cycle
      d.pwr = input_power_i;
      if (input_power_i && !q.pwr) begin
         d.cmd[0][ILIM_MSB:ILIM_LSB] = dflt;
         d.cmd[1][ILIM_MSB:ILIM_LSB] = dflt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         q         <= '0;
         q.st      <= S_IDLE;
         q.cmd     <= {sic_pkg::MASK_RESET, {3{sic_pkg::CMD_RESET}}};
         q.irq_n   <= 1'b1;
         q.sda_oen <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign smb.s_sda_o   = 1'b0;
   assign smb.s_sda_oen = q.sda_oen;
   assign smb.irq_n     = q.irq_n;
   assign cmd_o         = q.cmd;
   assign irq_pending_o = q.irqp;
endmodule : sic_slave

/* File: hdl/sic_master.sv */
// SMBus controller end: runs the four byte protocols on software orders
module sic_master (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       resetn_i,
   // Link
   sic_smb_if.master       smb,
   // Register port
   input  wire logic [2:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output logic      [7:0] rdata_o,
   output logic            busy_o
);
   typedef struct packed {
      logic                busy;
      logic                nack;
      sic_pkg::sic_kind_t  kind;
      sic_pkg::sic_op_t    op;
      logic [2:0]          step;
      logic [1:0]          qph;
      logic [7:0]          tick;
      logic [3:0]          cnt;
      logic [7:0]          sh;
      logic [7:0]          cmd;
      logic [7:0]          data;
      logic [7:0]          rxd;
      logic [7:0]          rdata;
      logic                scl;
      logic                sda_oen;
   } sic_mst_t;

   sic_mst_t   q;
   sic_mst_t   d;
   logic [1:0] lvl;

   // Order of phases for each protocol
   function automatic sic_pkg::sic_op_t op_at(input sic_pkg::sic_kind_t k,
                                              input logic [2:0] s);
      op_at = sic_pkg::OP_STOP;
      case (k)
         sic_pkg::K_WRBYTE: begin
            case (s)
               3'h0: op_at = sic_pkg::OP_START;
               3'h1: op_at = sic_pkg::OP_AW;
               3'h2: op_at = sic_pkg::OP_CMD;
               3'h3: op_at = sic_pkg::OP_DATA;
               default: op_at = sic_pkg::OP_STOP;
            endcase
         end
         sic_pkg::K_RDBYTE: begin
            case (s)
               3'h0: op_at = sic_pkg::OP_START;
               3'h1: op_at = sic_pkg::OP_AW;
               3'h2: op_at = sic_pkg::OP_CMD;
               3'h3: op_at = sic_pkg::OP_START;
               3'h4: op_at = sic_pkg::OP_AR;
               3'h5: op_at = sic_pkg::OP_RX;
               default: op_at = sic_pkg::OP_STOP;
            endcase
         end
         sic_pkg::K_SEND: begin
            case (s)
               3'h0: op_at = sic_pkg::OP_START;
               3'h1: op_at = sic_pkg::OP_AW;
               3'h2: op_at = sic_pkg::OP_CMD;
               default: op_at = sic_pkg::OP_STOP;
            endcase
         end
         default: begin
            case (s)
               3'h0: op_at = sic_pkg::OP_START;
               3'h1: op_at = sic_pkg::OP_AR;
               3'h2: op_at = sic_pkg::OP_RX;
               default: op_at = sic_pkg::OP_STOP;
            endcase
         end
      endcase
   endfunction : op_at

   sic_pin_sync #(.W(2), .RST_VAL(2'h3)) u_sync (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .async_i  ({smb.irq_n, smb.sda}),
      .lvl_o    (lvl),
      .prv_o    ()
   );

   always_comb begin
      d = q;
      if (rd_i) begin
         case (addr_i)
            sic_pkg::HR_STAT: d.rdata = {5'h00, ~lvl[1], q.nack, q.busy};
            sic_pkg::HR_RXD:  d.rdata = q.rxd;
            sic_pkg::HR_CMD:  d.rdata = q.cmd;
            sic_pkg::HR_DATA: d.rdata = q.data;
            default:          d.rdata = 8'h00;
         endcase
      end
      if (wr_i) begin
         case (addr_i)
            sic_pkg::HR_CMD:  d.cmd = wdata_i;
            sic_pkg::HR_DATA: d.data = wdata_i;
            sic_pkg::HR_CTRL: begin
               // An order while busy is dropped so the bus is never cut short
               if (!q.busy) begin
                  d.busy = 1'b1;
                  d.nack = 1'b0;
                  d.kind = sic_pkg::sic_kind_t'(wdata_i[1:0]);
                  d.step = '0;
                  d.op   = sic_pkg::OP_START;
                  d.qph  = '0;
                  d.tick = '0;
               end
            end
            default: d.rdata = d.rdata;
         endcase
      end
      if (q.busy) begin
         d.tick = q.tick + 8'h01;
         if (q.tick == sic_pkg::QTR_CYC - 8'h01) begin
            d.tick = '0;
            d.qph  = q.qph + 2'h1;
            case (q.op)
               sic_pkg::OP_START: begin
                  case (q.qph)
                     2'h0: d.sda_oen = 1'b1;
                     2'h1: d.scl = 1'b1;
                     2'h2: d.sda_oen = 1'b0;
                     default: d.scl = 1'b0;
                  endcase
               end
               sic_pkg::OP_STOP: begin
                  case (q.qph)
                     2'h0: d.sda_oen = 1'b0;
                     2'h1: d.scl = 1'b1;
                     2'h2: d.sda_oen = 1'b1;
                     default: d.busy = 1'b0;
                  endcase
               end
               default: begin
                  case (q.qph)
                     2'h0: d.sda_oen = (q.cnt == sic_pkg::BYTE_BITS) ||
                                       (q.op == sic_pkg::OP_RX) || q.sh[7];
                     2'h1: d.scl = 1'b1;
                     2'h2: begin
                        if (q.cnt != sic_pkg::BYTE_BITS) begin
                           d.sh = {q.sh[6:0], lvl[0]};
                        end else if (q.op != sic_pkg::OP_RX && lvl[0]) begin
                           d.nack = 1'b1;
                        end
                     end
                     default: begin
                        d.scl = 1'b0;
                        d.cnt = q.cnt + 4'h1;
                     end
                  endcase
               end
            endcase
            // Phase ends: pick the next one and preload its byte
            if (q.qph == 2'h3 && q.op != sic_pkg::OP_STOP &&
                (q.op == sic_pkg::OP_START || q.cnt == sic_pkg::BYTE_BITS)) begin
               d.cnt  = '0;
               d.step = q.step + 3'h1;
               d.op   = d.nack ? sic_pkg::OP_STOP : op_at(q.kind, d.step);
               if (q.op == sic_pkg::OP_RX) begin
                  d.rxd = q.sh;
               end
               case (d.op)
                  sic_pkg::OP_AW:   d.sh = {sic_pkg::SLAVE_ADDR, sic_pkg::RW_WRITE};
                  sic_pkg::OP_AR:   d.sh = {sic_pkg::SLAVE_ADDR, sic_pkg::RW_READ};
                  sic_pkg::OP_CMD:  d.sh = q.cmd;
                  sic_pkg::OP_DATA: d.sh = q.data;
                  default:          d.sh = sic_pkg::READ_IDLE;
               endcase
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         q         <= '0;
         q.op      <= sic_pkg::OP_STOP;
         q.scl     <= 1'b1;
         q.sda_oen <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign smb.scl       = q.scl;
   assign smb.m_sda_o   = 1'b0;
   assign smb.m_sda_oen = q.sda_oen;
   assign rdata_o       = q.rdata;
   assign busy_o        = q.busy;
endmodule : sic_master

/* File: sim/sic_smb_sva.sv */
// Link checker for the two-wire bus between controller and slave
module sic_smb_sva (
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Link
   input wire logic scl,
   input wire logic sda,
   input wire logic m_sda_o,
   input wire logic m_sda_oen,
   input wire logic s_sda_o,
   input wire logic s_sda_oen,
   input wire logic irq_n
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   chk_slave_pull_low: assert property (!s_sda_oen |-> !s_sda_o && !sda)
      else $error("slave drive not low");
   chk_master_pull_low: assert property (!m_sda_oen |-> !m_sda_o)
      else $error("controller drive not low");
   // Slave moves data only well inside the low phase, never across a clock rise
   chk_slave_edge_low: assert property ($changed(s_sda_oen) |-> !scl && !$past(scl, 2))
      else $error("slave changed sda near clock high");
   chk_scl_high_min: assert property ($rose(scl) |=> scl [*8])
      else $error("clock high too short");
   chk_scl_low_min: assert property ($fell(scl) |=> !scl [*8])
      else $error("clock low too short");
   chk_irq_level: assert property ($fell(irq_n) |=> !irq_n [*8])
      else $error("interrupt line pulsed");
   chk_irq_clear_ack: assert property ($rose(irq_n) |-> !s_sda_oen || !$past(s_sda_oen))
      else $error("interrupt released outside an acknowledge");
   chk_stop_release: assert property ($rose(sda) && scl |=> s_sda_oen [*8])
      else $error("slave drives after stop");
endmodule : sic_smb_sva

/* File: sim/testbench.sv */
// Bench joining controller and slave over the link
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic            clk_i    = 1'b0;
   logic            resetn_i = 1'b0;
   logic [2:0][7:0] status   = '0;
   logic            pwr      = 1'b1;
   logic            rset     = 1'b0;
   logic [2:0]      addr     = '0;
   logic [7:0]      wdata    = '0;
   logic            wr       = 1'b0;
   logic            rd       = 1'b0;
   logic [3:0][7:0] cmd;
   logic            pend;
   logic [7:0]      rdata;
   logic            busy;
   logic [7:0]      d;
   int              miscompares = 0;
   int              n_checks    = 0;
   sic_smb_if i_sic_smb_if ();
   sic_slave i_sic_slave (.clk_i(clk_i), .resetn_i(resetn_i), .smb(i_sic_smb_if.slave),
      .status_i(status), .input_power_i(pwr), .rset_default_i(rset), .cmd_o(cmd),
      .irq_pending_o(pend));
   sic_master i_sic_master (.clk_i(clk_i), .resetn_i(resetn_i), .smb(i_sic_smb_if.master),
      .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .busy_o(busy));
   sic_smb_sva i_sic_smb_sva (.clk_i(clk_i), .resetn_i(resetn_i), .scl(i_sic_smb_if.scl),
      .sda(i_sic_smb_if.sda), .m_sda_o(i_sic_smb_if.m_sda_o),
      .m_sda_oen(i_sic_smb_if.m_sda_oen), .s_sda_o(i_sic_smb_if.s_sda_o),
      .s_sda_oen(i_sic_smb_if.s_sda_oen), .irq_n(i_sic_smb_if.irq_n));
   always #12.5 clk_i = ~clk_i;
   task automatic wrap_up();
      if (miscompares == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : wrap_up
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic hw(input logic [2:0] a, input logic [7:0] v);
      @(posedge clk_i);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk_i);
      wr <= 1'b0;
   endtask : hw
   task automatic hr(input logic [2:0] a);
      @(posedge clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : hr
   // Runs one bus protocol; leaves the received byte in d
   task automatic xfer(input logic [1:0] kind, input logic [7:0] c, input logic [7:0] v);
      int n;
      n = 0;
      hw(sic_pkg::HR_CMD, c);
      hw(sic_pkg::HR_DATA, v);
      hw(sic_pkg::HR_CTRL, {6'h00, kind});
      @(posedge clk_i) #1;
      while (busy !== 1'b0 && n < 30000) begin
         @(posedge clk_i) #1 n++;
      end
      chk("busy", {7'h00, busy}, 8'h00);
      hr(sic_pkg::HR_STAT);
      chk("nack", {7'h00, d[sic_pkg::SB_NACK]}, 8'h00);
      hr(sic_pkg::HR_RXD);
   endtask : xfer
   task automatic t_reset();
      @(posedge clk_i) #1;
      chk("mask after reset", cmd[3], 8'h00);
      chk("irq line after reset", {7'h00, i_sic_smb_if.irq_n}, 8'h01);
      hr(3'h7);
      chk("unmapped read", d, 8'h00);
   endtask : t_reset
   task automatic t_write_read();
      xfer(sic_pkg::K_WRBYTE, sic_pkg::PTR_CMD0, 8'h15);
      chk("command 0", cmd[0], 8'h15);
      @(posedge clk_i);
      status[0] <= 8'h5A;
      xfer(sic_pkg::K_RDBYTE, sic_pkg::PTR_ST0, 8'h00);
      chk("read byte", d, 8'h5A);
      @(posedge clk_i);
      status[0] <= 8'h3C;
      xfer(sic_pkg::K_RECV, 8'h00, 8'h00);
      chk("receive byte", d, 8'h3C);
   endtask : t_write_read
   task automatic t_irq();
      xfer(sic_pkg::K_WRBYTE, sic_pkg::PTR_MASK, 8'h90);
      chk("mask", cmd[3], 8'h90);
      chk("no irq yet", {7'h00, pend}, 8'h00);
      // Only the charger field moves; the host power bits stay put
      @(posedge clk_i);
      status[0] <= 8'hBC;
      repeat (20) @(posedge clk_i);
      #1 chk("irq line", {7'h00, i_sic_smb_if.irq_n}, 8'h00);
      hr(sic_pkg::HR_STAT);
      chk("status irq", {7'h00, d[sic_pkg::SB_IRQ]}, 8'h01);
      @(posedge clk_i);
      status[0] <= 8'h40;
      xfer(sic_pkg::K_SEND, sic_pkg::PTR_ST0, 8'h00);
      chk("command 0 kept", cmd[0], 8'h15);
      chk("mask kept", cmd[3], 8'h90);
      xfer(sic_pkg::K_RECV, 8'h00, 8'h00);
      chk("frozen status", d, 8'hBC);
      @(posedge clk_i);
      status[0] <= 8'hBC;
      xfer(sic_pkg::K_WRBYTE, sic_pkg::PTR_MASK, 8'h90);
      chk("irq cleared", {7'h00, i_sic_smb_if.irq_n}, 8'h01);
      // Reverse supply flag sits in byte 0x03 under the host power category
      @(posedge clk_i);
      status[0] <= 8'hB8;
      repeat (20) @(posedge clk_i);
      #1 chk("host power irq", {7'h00, pend}, 8'h01);
   endtask : t_irq
   task automatic t_power(input logic rs);
      logic [7:0] e;
      e = {3'h0, rs ? sic_pkg::ILIM_RSET : sic_pkg::ILIM_100MA};
      @(posedge clk_i);
      rset <= rs;
      pwr <= 1'b0;
      repeat (8) @(posedge clk_i);
      pwr <= 1'b1;
      repeat (8) @(posedge clk_i);
      #1 chk("usb limit", cmd[0], e);
      chk("adapter limit", cmd[1], e);
   endtask : t_power
   initial begin
      #3000000;
      miscompares++;
      wrap_up();
   end
   initial begin
      repeat (20) @(posedge clk_i);
      resetn_i <= 1'b1;
      t_reset();
      t_write_read();
      t_irq();
      t_power(1'b0);
      t_power(1'b1);
      xfer(sic_pkg::K_RDBYTE, sic_pkg::PTR_CMD0, 8'h00);
      chk("limit readback", d, 8'h1F);
      wrap_up();
   end
endmodule : testbench
